// file: rfp_pcs.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module rfp_pcs #(
	parameter int SD_ON_CYC = rfp_pkg::SD_ON_CYC,
	parameter int SD_OFF_CYC = rfp_pkg::SD_OFF_CYC,
	parameter int LINK_MIN_CYC = rfp_pkg::LINK_MIN_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// rmii transmit
	input wire logic tx_en,
	input wire logic [1:0] txd,
	// rmii receive
	output logic crs_dv,
	output logic [1:0] rxd,
	output logic rx_er,
	// carrier and collision
	output logic carrier_sense,
	output logic col,
	// media side code stream
	output logic [4:0] tx_code,
	output logic tx_code_strobe,
	input wire logic rx_code_bit,
	input wire logic rx_energy,
	input wire logic fiber_energy_input,
	output logic signal_detect_flag,
	output logic link_pass,
	// straps
	input wire logic scrambler_strap,
	input wire logic [4:0] phy_addr
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic phase;
		logic pend;
		logic [1:0] lo;
		logic [3:0] div;
		rfp_pkg::rfp_tx_st_t tx_state;
		logic [4:0] tx_raw;
		logic [4:0] tx_code;
		logic tx_strobe;
		logic [10:0] scr;
		logic capt;
		logic strap;
		rfp_pkg::rfp_rx_st_t rx_state;
		logic [9:0] sr;
		logic [2:0] bcnt;
		logic [10:0] dsc;
		logic [1:0] rxd;
		logic [1:0] rx_hi;
		logic rx_hi_pend;
		logic rx_er;
		logic sd_raw;
		logic [19:0] on_cnt;
		logic [19:0] off_cnt;
		rfp_pkg::rfp_link_t link;
		logic [19:0] link_cnt;
		logic [31:0] ctrl;
		logic [31:0] ext;
		logic [31:0] prdata;
		logic pslverr;
	} rfp_state_t;

	rfp_state_t q;
	rfp_state_t n;

	logic speed100;
	logic fiber_act;
	logic scr_act;
	logic sample;
	logic energy;
	logic rx_d;
	logic dsc_key;
	logic [4:0] dec;
	logic [4:0] mask;
	logic [10:0] lf;
	logic [3:0] nib;
	logic boundary;
	logic apb_wr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// mode decode
	// ****************************************************************
	// fiber is refused on every other port, whatever software asks
	assign speed100 = q.ctrl[rfp_pkg::CTRL_SPEED_BIT];
	assign fiber_act = q.ctrl[rfp_pkg::CTRL_FIBER_BIT] && speed100
		&& (phy_addr[1:0] == rfp_pkg::FIBER_PORT);
	assign scr_act = q.strap && q.ext[rfp_pkg::EXT_SCR_BIT] && speed100 && !fiber_act;
	assign energy = fiber_act ? fiber_energy_input : rx_energy;
	// slow mode: one dibit taken per ten clocks, from whatever phase
	assign sample = speed100 || (q.div == 4'h0);
	assign dsc_key = q.dsc[rfp_pkg::SCR_TAP_HI] ^ q.dsc[rfp_pkg::SCR_TAP_LO];
	assign rx_d = scr_act ? (rx_code_bit ^ dsc_key) : rx_code_bit;
	assign nib = {txd, q.lo};
	assign apb_wr = psel && penable && pwrite;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		n = q;
		mask = 5'h00;
		lf = q.scr;
		dec = 5'h00;
		boundary = 1'b0;
		n.tx_strobe = 1'b0;
		n.div = (q.div == rfp_pkg::TEN_DIV_LAST) ? 4'h0 : q.div + 4'h1;

		// strap and seed caught on the first edge after reset release
		if (!q.capt)
		begin
			n.capt = 1'b1;
			n.strap = scrambler_strap;
			n.scr = {rfp_pkg::SEED_FILL, phy_addr};
		end

		// transmit: pair dibits into nibbles, frame with delimiters
		if (sample)
		begin
			if (q.tx_state == rfp_pkg::TX_IDLE && tx_en && !q.pend)
			begin
				n.lo = txd;
				n.pend = 1'b1;
				n.phase = 1'b1;
			end
			else
			begin
				n.phase = ~q.phase;
				boundary = q.phase;
				if (!q.phase && tx_en)
				begin
					n.lo = txd;
				end
			end
		end
		if (boundary)
		begin
			n.pend = 1'b0;
			n.tx_strobe = 1'b1;
			n.tx_raw = rfp_pkg::CG_I;
			n.tx_state = rfp_pkg::TX_IDLE;
			case (q.tx_state)
				rfp_pkg::TX_IDLE:
				begin
					// first preamble nibble is replaced by J
					if (q.pend && tx_en && q.link == rfp_pkg::LNK_PASS)
					begin
						n.tx_state = rfp_pkg::TX_J;
						n.tx_raw = rfp_pkg::CG_J;
					end
				end
				rfp_pkg::TX_J:
				begin
					n.tx_state = rfp_pkg::TX_K;
					n.tx_raw = rfp_pkg::CG_K;
				end
				rfp_pkg::TX_K, rfp_pkg::TX_DATA:
				begin
					if (tx_en)
					begin
						n.tx_state = rfp_pkg::TX_DATA;
						n.tx_raw = q.ctrl[rfp_pkg::CTRL_TXERR_BIT] ? rfp_pkg::CG_H
							: rfp_pkg::rfp_enc(nib);
					end
					else
					begin
						n.tx_state = rfp_pkg::TX_T;
						n.tx_raw = rfp_pkg::CG_T;
					end
				end
				rfp_pkg::TX_T:
				begin
					n.tx_state = rfp_pkg::TX_R;
					n.tx_raw = rfp_pkg::CG_R;
				end
				default:
				begin
					n.tx_state = rfp_pkg::TX_IDLE;
				end
			endcase
			// add the cipher stream one code bit at a time, first bit on the msb
			for (int i = 4; i >= 0; i--)
			begin
				mask[i] = lf[rfp_pkg::SCR_TAP_HI] ^ lf[rfp_pkg::SCR_TAP_LO];
				lf = {lf[9:0], mask[i]};
			end
			if (scr_act && q.capt)
			begin
				n.scr = lf;
			end
			n.tx_code = scr_act ? (n.tx_raw ^ mask) : n.tx_raw;
		end

		// descrambler: during idle every plain bit is one, so the line bit
		// reveals the key; while a stream runs the generator free-runs
		if (q.rx_state == rfp_pkg::RX_IDLE)
		begin
			n.dsc = {q.dsc[9:0], ~rx_code_bit};
		end
		else
		begin
			n.dsc = {q.dsc[9:0], dsc_key};
		end

		// receive: align, decode, report
		n.sr = {q.sr[8:0], rx_d};
		n.bcnt = q.bcnt + 3'h1;
		n.rx_er = 1'b0;
		n.rxd = q.rx_hi_pend ? q.rx_hi : 2'h0;
		n.rx_hi_pend = 1'b0;
		case (q.rx_state)
			rfp_pkg::RX_IDLE:
			begin
				n.bcnt = 3'h0;
				if (!rx_d && q.link == rfp_pkg::LNK_PASS)
				begin
					n.rx_state = rfp_pkg::RX_CARR;
				end
			end
			rfp_pkg::RX_CARR:
			begin
				if (q.bcnt == rfp_pkg::RX_JK_BITS - 3'h1)
				begin
					n.bcnt = 3'h0;
					// anything but J/K at the start is false carrier
					n.rx_state = (n.sr == rfp_pkg::CG_JK) ? rfp_pkg::RX_DATA
						: rfp_pkg::RX_FALSE;
				end
			end
			rfp_pkg::RX_DATA:
			begin
				if (q.bcnt == rfp_pkg::RX_GROUP_LAST)
				begin
					n.bcnt = 3'h0;
					dec = rfp_pkg::rfp_dec(n.sr[4:0]);
					if (n.sr[4:0] == rfp_pkg::CG_T)
					begin
						n.rx_state = rfp_pkg::RX_ENDR;
					end
					else if (n.sr[4:0] == rfp_pkg::CG_I)
					begin
						n.rx_state = rfp_pkg::RX_IDLE;
					end
					else if (dec[4])
					begin
						n.rxd = dec[1:0];
						n.rx_hi = dec[3:2];
						n.rx_hi_pend = 1'b1;
					end
					else
					begin
						n.rx_er = 1'b1;
					end
				end
			end
			rfp_pkg::RX_ENDR:
			begin
				if (q.bcnt == rfp_pkg::RX_GROUP_LAST)
				begin
					n.rx_er = (n.sr[4:0] != rfp_pkg::CG_R);
					n.rx_state = rfp_pkg::RX_IDLE;
				end
			end
			default:
			begin
				if (n.sr == {rfp_pkg::CG_I, rfp_pkg::CG_I})
				begin
					n.rx_state = rfp_pkg::RX_IDLE;
				end
			end
		endcase
		if (n.rx_state == rfp_pkg::RX_FALSE)
		begin
			n.rxd = rfp_pkg::RXD_FALSE;
			n.rx_er = 1'b1;
		end

		// signal detect with separate rise and fall qualification
		if (energy)
		begin
			n.off_cnt = 20'h0;
			if (q.on_cnt == 20'(SD_ON_CYC - 1))
			begin
				n.sd_raw = 1'b1;
			end
			else
			begin
				n.on_cnt = q.on_cnt + 20'h1;
			end
		end
		else
		begin
			n.on_cnt = 20'h0;
			if (q.off_cnt == 20'(SD_OFF_CYC - 1))
			begin
				n.sd_raw = 1'b0;
			end
			else
			begin
				n.off_cnt = q.off_cnt + 20'h1;
			end
		end

		// link monitor
		if (!signal_detect_flag)
		begin
			n.link = rfp_pkg::LNK_FAIL;
			n.link_cnt = 20'h0;
		end
		else if (q.link_cnt == 20'(LINK_MIN_CYC - 1))
		begin
			n.link = rfp_pkg::LNK_PASS;
		end
		else
		begin
			n.link_cnt = q.link_cnt + 20'h1;
		end

		// apb: read data latched in setup, writes land in access
		if (psel && !penable)
		begin
			n.pslverr = 1'b0;
			n.prdata = 32'h0;
			if (paddr == rfp_pkg::REG_CTRL)
			begin
				n.prdata = q.ctrl;
			end
			else if (paddr == rfp_pkg::REG_EXT)
			begin
				n.prdata = q.ext;
			end
			else if (paddr == rfp_pkg::REG_STAT)
			begin
				n.prdata = {22'h0, q.tx_state != rfp_pkg::TX_IDLE, q.rx_state != rfp_pkg::RX_IDLE,
					3'h0, q.strap, fiber_act, scr_act, link_pass, signal_detect_flag};
			end
			else
			begin
				n.pslverr = 1'b1;
			end
		end
		if (apb_wr && paddr == rfp_pkg::REG_CTRL)
		begin
			n.ctrl = pwdata;
		end
		else if (apb_wr && paddr == rfp_pkg::REG_EXT)
		begin
			n.ext = pwdata;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.tx_raw <= rfp_pkg::CG_I;
			q.tx_code <= rfp_pkg::CG_I;
			q.sr <= {rfp_pkg::CG_I, rfp_pkg::CG_I};
			q.ctrl <= rfp_pkg::CTRL_RST;
			q.ext <= rfp_pkg::EXT_RST;
		end
		else
		begin
			q <= n;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// loopbacks override the qualified energy detect
	assign signal_detect_flag = q.ctrl[rfp_pkg::CTRL_LLPBK_BIT] ? 1'b0
		: (q.ext[rfp_pkg::EXT_RLPBK_BIT] ? 1'b1 : q.sd_raw);
	assign link_pass = (q.link == rfp_pkg::LNK_PASS);
	assign col = (q.tx_state != rfp_pkg::TX_IDLE) && (q.rx_state != rfp_pkg::RX_IDLE);
	assign carrier_sense = (q.tx_state != rfp_pkg::TX_IDLE)
		|| (q.rx_state != rfp_pkg::RX_IDLE);
	assign crs_dv = (q.rx_state != rfp_pkg::RX_IDLE);
	assign rxd = q.rxd;
	assign rx_er = q.rx_er;
	assign tx_code = q.tx_code;
	assign tx_code_strobe = q.tx_strobe;
	assign prdata = q.prdata;
	assign pready = 1'b1;
	assign pslverr = q.pslverr && psel && penable;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_grp(logic [4:0] cg);
		q.tx_strobe && q.tx_raw == cg;
	endsequence

	AST_TX_IGNORE: assert property (
		(q.tx_state == rfp_pkg::TX_IDLE && !q.pend && !tx_en) |=> !q.pend)
		else $error("dibit taken without transmit enable");
	AST_NIBBLE_RATE: assert property (
		(speed100 && q.tx_strobe && q.tx_state != rfp_pkg::TX_IDLE) |=> !q.tx_strobe ##1 q.tx_strobe)
		else $error("groups not every second clock");
	AST_FIBER_PLAIN: assert property (
		fiber_act |-> !scr_act && phy_addr[1:0] == rfp_pkg::FIBER_PORT)
		else $error("fiber scrambled or on wrong port");
	AST_COLLIDE: assert property (
		(q.tx_state != rfp_pkg::TX_IDLE && crs_dv) |-> col && carrier_sense)
		else $error("collision missed");
	AST_START_PAIR: assert property (
		(speed100 && q.tx_strobe && q.tx_raw == rfp_pkg::CG_J)
		|=> !q.tx_strobe ##1 s_grp(rfp_pkg::CG_K))
		else $error("J not followed by K");
	AST_END_PAIR: assert property (
		(speed100 && q.tx_strobe && q.tx_raw == rfp_pkg::CG_T)
		|=> !q.tx_strobe ##1 s_grp(rfp_pkg::CG_R))
		else $error("T not followed by R");
	AST_IDLE_FILL: assert property (
		(q.tx_strobe && q.tx_state == rfp_pkg::TX_IDLE) |-> q.tx_raw == rfp_pkg::CG_I)
		else $error("fill is not idle");
	AST_FALSE_CARRIER: assert property (
		(q.rx_state == rfp_pkg::RX_FALSE) |-> rxd == rfp_pkg::RXD_FALSE && rx_er && crs_dv)
		else $error("false carrier not reported");
	AST_STRAP_OFF: assert property (
		(q.capt && !q.strap) |-> !scr_act)
		else $error("scrambling despite strap low");
	AST_LOCAL_LOOP: assert property (
		q.ctrl[rfp_pkg::CTRL_LLPBK_BIT] |-> !signal_detect_flag ##1 !link_pass)
		else $error("signal detect not forced low");
	AST_LINK_FAIL: assert property (
		(!link_pass && q.tx_state == rfp_pkg::TX_IDLE) |=> q.tx_state == rfp_pkg::TX_IDLE)
		else $error("stream started in link fail");

endmodule

// file: rfp_pkg.sv
package rfp_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ = 100;
	localparam int SD_ON_US = 2000;
	localparam int SD_OFF_US = 1000;
	localparam int LINK_MIN_US = 1000;
	localparam int SD_ON_CYC = SD_ON_US * CLK_MHZ;
	localparam int SD_OFF_CYC = SD_OFF_US * CLK_MHZ;
	localparam int LINK_MIN_CYC = LINK_MIN_US * CLK_MHZ;
	localparam logic [3:0] TEN_DIV_LAST = 4'h9;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_EXT = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam int CTRL_SPEED_BIT = 0;
	localparam int CTRL_FIBER_BIT = 1;
	localparam int CTRL_TXERR_BIT = 4;
	localparam int CTRL_LLPBK_BIT = 14;
	localparam int EXT_SCR_BIT = 2;
	localparam int EXT_RLPBK_BIT = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] EXT_RST = 32'h0000_0004;
	localparam logic [1:0] FIBER_PORT = 2'h3;
	localparam logic [5:0] SEED_FILL = 6'h01;
	localparam int SCR_TAP_HI = 10;
	localparam int SCR_TAP_LO = 8;

	// ****************************************************************
	// code-groups
	// ****************************************************************
	localparam logic [4:0] CG_I = 5'h1f;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0d;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [4:0] CG_H = 5'h04;
	localparam logic [9:0] CG_JK = {CG_J, CG_K};
	localparam logic [2:0] RX_JK_BITS = 3'h7;
	localparam logic [2:0] RX_GROUP_LAST = 3'h4;
	localparam logic [1:0] RXD_FALSE = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_J = 3'h1, TX_K = 3'h3, TX_DATA = 3'h2, TX_T = 3'h6, TX_R = 3'h7
	} rfp_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_CARR = 3'h1, RX_DATA = 3'h3, RX_ENDR = 3'h2, RX_FALSE = 3'h6
	} rfp_rx_st_t;
	typedef enum logic {LNK_FAIL = 1'b0, LNK_PASS = 1'b1} rfp_link_t;

	// nibble to data code-group
	function automatic logic [4:0] rfp_enc(input logic [3:0] n);
		logic [4:0] c;
		c = 5'h1e;
		case (n)
			4'h0: c = 5'h1e;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0a;
			4'h5: c = 5'h0b;
			4'h6: c = 5'h0e;
			4'h7: c = 5'h0f;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'ha: c = 5'h16;
			4'hb: c = 5'h17;
			4'hc: c = 5'h1a;
			4'hd: c = 5'h1b;
			4'he: c = 5'h1c;
			default: c = 5'h1d;
		endcase
		return c;
	endfunction

	// data code-group to {valid, nibble}; anything else is invalid
	function automatic logic [4:0] rfp_dec(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++)
		begin
			if (rfp_enc(4'(i)) == c)
			begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

endpackage

// file: rfp_mac_model.sv
`timescale 1ns/1ps

// ****************************************************************
// mac side transmit model
// ****************************************************************
module rfp_mac_model (
	// clock
	pclk,
	// rmii transmit
	tx_en,
	txd
);
	input wire logic pclk;
	output logic tx_en;
	output logic [1:0] txd;
	logic busy;

	initial
	begin
		tx_en = 1'b0;
		txd = 2'h0;
		busy = 1'b0;
	end

	// between frames txd toggles so a stale dibit never looks like data
	always @(posedge pclk)
		if (!busy)
			txd <= ~txd;

	// one dibit per clock, low dibit of each octet first
	task automatic send(input logic [7:0] b[$]);
		busy = 1'b1;
		foreach (b[i])
			for (int k = 0; k < 4; k++)
			begin
				@(posedge pclk);
				tx_en <= 1'b1;
				txd <= b[i][2*k+:2];
			end
		@(posedge pclk);
		tx_en <= 1'b0;
		busy = 1'b0;
	endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps

module tb;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] txd, rxd;
	logic crs_dv, rx_er, carrier_sense, col, tx_code_strobe, rx_code_bit;
	logic rx_energy, fiber_energy_input, signal_detect_flag, link_pass, scrambler_strap, e;
	logic [4:0] tx_code, phy_addr;
	logic [4:0] txq[$];
	logic [1:0] rxq[$];
	int seed, fail_count, cmp_count, n;
	localparam logic [4:0] ENC[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
		5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	localparam logic [3:0] PICK[6] = '{4'h6, 4'h7, 4'ha, 4'hb, 4'he, 4'hf};

	rfp_pcs #(.SD_ON_CYC(20), .SD_OFF_CYC(10), .LINK_MIN_CYC(10)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_en(tx_en),
		.txd(txd), .crs_dv(crs_dv), .rxd(rxd), .rx_er(rx_er), .carrier_sense(carrier_sense),
		.col(col), .tx_code(tx_code), .tx_code_strobe(tx_code_strobe),
		.rx_code_bit(rx_code_bit), .rx_energy(rx_energy),
		.fiber_energy_input(fiber_energy_input), .signal_detect_flag(signal_detect_flag),
		.link_pass(link_pass), .scrambler_strap(scrambler_strap), .phy_addr(phy_addr));
	rfp_mac_model u_mac (.pclk(pclk), .tx_en(tx_en), .txd(txd));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// capture every code-group strobe and every non-zero received dibit
	always @(posedge pclk)
	begin
		if (tx_code_strobe === 1'b1)
			txq.push_back(tx_code);
		if (crs_dv === 1'b1 && rxd !== 2'h0)
			rxq.push_back(rxd);
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// a wait that ran out of bound ends the run as a mismatch
	task bound(input int k, input int lim);
		if (k >= lim)
		begin
			fail_count++;
			end_sim;
		end
	endtask

	task rst(input logic s, input logic [4:0] a);
		presetn <= 1'b0;
		scrambler_strap <= s;
		phy_addr <= a;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		n = 0;
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		bound(n, 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_lvl(input logic v, input int lo, input int hi);
		n = 0;
		while ((v ? signal_detect_flag : link_pass) !== 1'b1 && n < 100)
		begin
			n++;
			@(posedge pclk);
		end
		bound(n, 100);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task grp(input logic [4:0] g);
		for (int k = 4; k >= 0; k--)
		begin
			@(posedge pclk);
			rx_code_bit <= g[k];
		end
	endtask

	// frame of preamble plus n octets; expect J K, data or H, T R, idle
	task automatic tx_frame(input int cnt, input logic herr);
		logic [7:0] b[$];
		logic [4:0] x[$];
		logic [7:0] v;
		b = {8'h55};
		x = {rfp_pkg::CG_J, rfp_pkg::CG_K};
		for (int i = 0; i < cnt; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			b.push_back(v);
			x.push_back(herr ? rfp_pkg::CG_H : ENC[v[3:0]]);
			x.push_back(herr ? rfp_pkg::CG_H : ENC[v[7:4]]);
		end
		x.push_back(rfp_pkg::CG_T);
		x.push_back(rfp_pkg::CG_R);
		x.push_back(rfp_pkg::CG_I);
		txq.delete();
		u_mac.send(b);
		repeat (30) @(posedge pclk);
		while (txq.size() > 0 && txq[0] === rfp_pkg::CG_I)
			void'(txq.pop_front());
		foreach (x[i])
		begin
			if (txq.size() == 0)
				txq.push_back(5'h00);
			chk({27'h0, txq.pop_front()}, {27'h0, x[i]});
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{psel, penable, pwrite, tx_en, rx_energy, fiber_energy_input} = '0;
		{paddr, pwdata} = '0;
		rx_code_bit = 1'b1;
		presetn = 1'b0;
		seed = 33298;
		rst(1'b0, 5'h03);
		apb(0, rfp_pkg::REG_CTRL, 0);
		chk(r, rfp_pkg::CTRL_RST);
		apb(0, rfp_pkg::REG_EXT, 0);
		chk(r, rfp_pkg::EXT_RST);
		apb(0, 12'h010, 0);
		chk({r[30:0], e}, 32'h1);
		apb(1, rfp_pkg::REG_STAT, 32'hffff_ffff);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk({r[4], r[2]}, 32'h0);
		rx_energy <= 1'b1;
		fiber_energy_input <= 1'b1;
		wait_lvl(1, 19, 25);
		wait_lvl(0, 9, 15);
		apb(1, rfp_pkg::REG_CTRL, 32'h3);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk({r[3], r[2]}, 32'h2);
		apb(1, rfp_pkg::REG_CTRL, 32'h1);
		tx_frame(6, 0);
		apb(1, rfp_pkg::REG_CTRL, 32'h11);
		tx_frame(2, 1);
		apb(1, rfp_pkg::REG_CTRL, 32'h1);
		begin
			logic [1:0] x[$];
			logic [3:0] v;
			rxq.delete();
			grp(rfp_pkg::CG_J);
			grp(rfp_pkg::CG_K);
			for (int i = 0; i < 4; i++)
			begin
				v = PICK[{$random(seed)} % 6];
				grp(ENC[v]);
				x.push_back(v[1:0]);
				x.push_back(v[3:2]);
			end
			grp(rfp_pkg::CG_T);
			grp(rfp_pkg::CG_R);
			repeat (20) @(posedge pclk);
			while (rxq.size() > 0 && rxq[0] === 2'h1)
				void'(rxq.pop_front());
			chk(rxq.size(), x.size());
			foreach (x[i])
				if (rxq.size() > i)
					chk(rxq[i], x[i]);
		end
		fork
			u_mac.send({8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55});
			begin
				repeat (3) @(posedge pclk);
				grp(5'h00);
				grp(5'h00);
				repeat (4) @(posedge pclk);
				chk({col, carrier_sense, rx_er, rxd}, {3'h7, rfp_pkg::RXD_FALSE});
			end
		join
		rx_code_bit <= 1'b1;
		repeat (16) @(posedge pclk);
		chk(crs_dv, 1'b0);
		apb(1, rfp_pkg::REG_CTRL, 32'h4001);
		repeat (2) @(posedge pclk);
		chk(signal_detect_flag, 1'b0);
		apb(1, rfp_pkg::REG_CTRL, 32'h1);
		wait_lvl(0, 0, 15);
		rx_energy <= 1'b0;
		fiber_energy_input <= 1'b0;
		n = 0;
		while (signal_detect_flag !== 1'b0 && n < 100)
		begin
			n++;
			@(posedge pclk);
		end
		bound(n, 100);
		chk({31'h0, n >= 9 && n <= 15}, 32'h1);
		repeat (2) @(posedge pclk);
		chk(link_pass, 1'b0);
		apb(1, rfp_pkg::REG_EXT, 32'hc);
		repeat (2) @(posedge pclk);
		chk(signal_detect_flag, 1'b1);
		rst(1'b1, 5'h01);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk({r[4], r[2]}, 32'h3);
		apb(1, rfp_pkg::REG_CTRL, 32'h3);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk(r[3], 1'b0);
		apb(1, rfp_pkg::REG_CTRL, 32'h0);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk(r[2], 1'b0);
		apb(1, rfp_pkg::REG_CTRL, 32'h1);
		apb(1, rfp_pkg::REG_EXT, 32'h0);
		apb(0, rfp_pkg::REG_STAT, 0);
		chk(r[2], 1'b0);
		end_sim;
	end
endmodule
